// File: logic/alu_unit.sv
/*
 Combinational arithmetic unit for the supported operations.
 Assumes operands are stable for the cycle in which the result is taken.
*/
`timescale 1ns/10ps
`default_nettype none

module alu_unit (
	input  wire core_pkg::op_e     op,
	input  wire logic [7:0]        accum,
	input  wire logic [7:0]        operand,
	input  wire logic [2:0]        bit_sel,
	input  wire core_pkg::status_s status_in,
	output logic [7:0]             result,
	output var core_pkg::status_s  next_status
);
	import core_pkg::*;

	logic [8:0] sum;
	logic [4:0] half;

	// Result and flags; untouched flags keep their value
	always_comb begin
		sum         = 9'(accum) + 9'(operand) + 9'(status_in.c);
		half        = 5'(accum[3:0]) + 5'(operand[3:0]) + 5'(status_in.c);
		result      = accum;
		next_status = status_in;
		case (op)
			op_add_carry: begin
				result         = sum[7:0];
				next_status.c  = sum[8];
				next_status.digit_carry_flag = half[4];
				// Overflow only when like signs give an unlike sign
				next_status.ov = (accum[7] == operand[7]) && (sum[7] != accum[7]);
				next_status.z  = (sum[7:0] == 8'h00);
				next_status.n  = sum[7];
			end
			op_and_lit, op_and_file: begin
				result        = accum & operand;
				next_status.z = ((accum & operand) == 8'h00);
				next_status.n = accum[7] & operand[7];
			end
			op_bit_clear: begin
				result = operand & ~(8'h01 << bit_sel);
			end
			default: begin
			end
		endcase
	end

endmodule : alu_unit

`default_nettype wire

// File: logic/instr_exec.sv
/*
 Decode and execute of an instruction subset: add with carry, two ANDs,
 bit clear and two conditional branches, with flags and program counter.
 Assumes the fetch path shows the word at instruction_pointer during Q1,
 and the file memory answers a read one cycle after file_req.rd.
*/
// Local design decisions: the plain strobed port and the register addresses.
// How it works
// - Add accumulator, file, carry; set five flags
// - Destination bit picks accumulator or file
// - Bank bit picks access bank or selector
// - Extended mode uses indexed offset below 60h
// - AND literal into accumulator, N and Z
// - AND accumulator with file, chosen destination
// - Branch on carry, flags untouched
// - Taken branch adds twice offset to pointer
// - Taken branch costs an extra idle cycle
// - Branch on negative, flags untouched
`timescale 1ns/10ps
`default_nettype none
`include "core_consts.svh"

module instr_exec #(
	parameter int PC_W = 21
) (
	input  wire logic [15:0]            instr_word,
	input  wire logic                   clk_sys,
	input  wire logic                   reset,
	input  wire logic                   instr_valid,
	input  wire logic [7:0]             file_rdata,
	input  wire logic [`BUS_ADDR_W-1:0] bus_addr,
	input  wire logic [7:0]             bus_wdata,
	input  wire logic                   bus_wr,
	input  wire logic                   bus_rd,
	output var core_pkg::file_req_s     file_req,
	output var core_pkg::status_s       status,
	output var core_pkg::phase_e        phase,
	output logic [7:0]                  accum,
	output logic [PC_W-1:0]             instruction_pointer,
	output logic                        flush,
	output logic [7:0]                  bus_rdata
);
	import core_pkg::*;

	logic [15:0]             ir;
	op_e                     cur_op;
	logic [3:0]              bank_selector;
	logic                    ext_en;
	logic [`FILE_ADDR_W-1:0] index_base;
	logic [`FILE_ADDR_W-1:0] oper_addr;
	logic [7:0]              alu_res;
	status_s                 next_status;
	logic [7:0]              operand;
	logic [7:0]              next_rdata;
	logic [PC_W-1:0]         br_offset;
	logic                    uses_file;
	logic                    dest_file;
	logic                    to_accum;
	logic                    sets_flags;
	logic                    taken;

	// Map an instruction word onto one of the supported operations
	function automatic op_e decode_op(input logic [15:0] w);
		if (w[15:10] == `OPC_ADD_CARRY)
			return op_add_carry;
		else if (w[15:8] == `OPC_AND_LIT)
			return op_and_lit;
		else if (w[15:10] == `OPC_AND_FILE)
			return op_and_file;
		else if (w[15:8] == `OPC_BR_CARRY)
			return op_br_carry;
		else if (w[15:12] == `OPC_BIT_CLR)
			return op_bit_clear;
		else if (w[15:8] == `OPC_BR_NEG)
			return op_br_neg;
		return op_nop;
	endfunction : decode_op

	////////////////////////////////////////////////////////////////////////////
	// Decode helpers

	// Operation classes drawn from the latched word
	always_comb begin
		uses_file  = (cur_op == op_add_carry) || (cur_op == op_and_file) || (cur_op == op_bit_clear);
		dest_file  = (cur_op == op_bit_clear) ||
			(((cur_op == op_add_carry) || (cur_op == op_and_file)) && ir[`FLD_DEST_BIT]);
		to_accum   = (cur_op == op_and_lit) ||
			(((cur_op == op_add_carry) || (cur_op == op_and_file)) && !ir[`FLD_DEST_BIT]);
		sets_flags = (cur_op == op_add_carry) || (cur_op == op_and_lit) || (cur_op == op_and_file);
		taken      = ((cur_op == op_br_carry) && status.c) ||
			((cur_op == op_br_neg) && status.n);
		operand    = (cur_op == op_and_lit) ? ir[7:0] : file_rdata;
		br_offset  = {{(PC_W-9){ir[7]}}, ir[7:0], 1'b0};
	end

	// Operand address: banked, access or indexed
	operand_addr u_addr (
		.f          (ir[7:0]),
		.a          (ir[`FLD_BANK_BIT]),
		.ext_en     (ext_en),
		.bank_sel   (bank_selector),
		.index_base (index_base),
		.addr       (oper_addr)
	);

	// Arithmetic for the operation under way
	alu_unit u_alu (
		.op          (cur_op),
		.accum       (accum),
		.operand     (operand),
		.bit_sel     (ir[11:9]),
		.status_in   (status),
		.result      (alu_res),
		.next_status (next_status)
	);

	////////////////////////////////////////////////////////////////////////////
	// Phase sequence and instruction latch

	// Free-running four-phase counter
	always_ff @(posedge clk_sys) begin
		if (reset)
			phase <= ph_q1;
		else
			case (phase)
				ph_q1:   phase <= ph_q2;
				ph_q2:   phase <= ph_q3;
				ph_q3:   phase <= ph_q4;
				ph_q4:   phase <= ph_q1;
				default: phase <= ph_q1;
			endcase
	end

	// Word taken at the end of Q1; a flushed cycle runs as a no-operation
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ir     <= 16'h0000;
			cur_op <= op_nop;
		end else if (phase == ph_q1) begin
			ir     <= instr_word;
			cur_op <= (instr_valid && !flush) ? decode_op(instr_word) : op_nop;
		end
	end

	// Idle cycle after a taken branch, cleared at the next Q4
	always_ff @(posedge clk_sys) begin
		if (reset)
			flush <= 1'b0;
		else if (phase == ph_q4)
			flush <= taken;
	end

	////////////////////////////////////////////////////////////////////////////
	// Program counter

	// Step on each accepted fetch; a taken branch adds twice the offset in Q4
	always_ff @(posedge clk_sys) begin
		if (reset)
			instruction_pointer <= '0;
		else if ((phase == ph_q1) && instr_valid && !flush)
			instruction_pointer <= instruction_pointer + PC_W'(`PC_STEP);
		else if ((phase == ph_q4) && taken)
			instruction_pointer <= instruction_pointer + br_offset;
	end

	////////////////////////////////////////////////////////////////////////////
	// Data memory request

	// Read issued at the end of Q2, write issued at the end of Q4; address holds through
	always_ff @(posedge clk_sys) begin
		if (reset)
			file_req <= '0;
		else begin
			file_req.rd <= (phase == ph_q2) && uses_file;
			file_req.wr <= (phase == ph_q4) && dest_file;
			if (phase == ph_q2)
				file_req.addr <= oper_addr;
			if (phase == ph_q4)
				file_req.wdata <= alu_res;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Accumulator and flags

	// Core write in Q4 wins over a port write in the same cycle
	always_ff @(posedge clk_sys) begin
		if (reset)
			accum <= `RST_ACCUM;
		else if ((phase == ph_q4) && to_accum)
			accum <= alu_res;
		else if (bus_wr && (bus_addr == `REG_ACCUM))
			accum <= bus_wdata;
	end

	// Branches and bit clear leave the flags alone
	always_ff @(posedge clk_sys) begin
		if (reset)
			status <= `RST_STATUS;
		else if ((phase == ph_q4) && sets_flags)
			status <= next_status;
		else if (bus_wr && (bus_addr == `REG_STATUS))
			status <= bus_wdata[4:0];
	end

	////////////////////////////////////////////////////////////////////////////
	// Register port

	// Bank selector
	always_ff @(posedge clk_sys) begin
		if (reset)
			bank_selector <= `RST_BANK_SEL;
		else if (bus_wr && (bus_addr == `REG_BANK_SEL))
			bank_selector <= bus_wdata[3:0];
	end

	// Extended instruction set enable
	always_ff @(posedge clk_sys) begin
		if (reset)
			ext_en <= `RST_CTRL;
		else if (bus_wr && (bus_addr == `REG_CTRL))
			ext_en <= bus_wdata[`CTRL_EXT_BIT];
	end

	// Index base for literal offset addressing, split over two bytes
	always_ff @(posedge clk_sys) begin
		if (reset)
			index_base <= `RST_INDEX;
		else if (bus_wr && (bus_addr == `REG_INDEX_LO))
			index_base[7:0] <= bus_wdata;
		else if (bus_wr && (bus_addr == `REG_INDEX_HI))
			index_base[11:8] <= bus_wdata[3:0];
	end

	// Read mux; unmapped offsets read zero
	always_comb begin
		case (bus_addr)
			`REG_ACCUM:    next_rdata = accum;
			`REG_STATUS:   next_rdata = {3'h0, status};
			`REG_BANK_SEL: next_rdata = {4'h0, bank_selector};
			`REG_CTRL:     next_rdata = {7'h00, ext_en};
			`REG_INDEX_LO: next_rdata = index_base[7:0];
			`REG_INDEX_HI: next_rdata = {4'h0, index_base[11:8]};
			default:       next_rdata = 8'h00;
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clk_sys) begin
		if (reset)
			bus_rdata <= 8'h00;
		else
			bus_rdata <= bus_rd ? next_rdata : 8'h00;
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);

	logic [8:0] chk_sum;
	assign chk_sum = 9'(accum) + 9'(file_rdata) + 9'(status.c);

	property p_add_accum;
		(phase == ph_q4 && cur_op == op_add_carry && !ir[9]) |=>
			accum == $past(chk_sum[7:0]) && status.c == $past(chk_sum[8]);
	endproperty
	a_add_accum: assert property (p_add_accum) else $error("add to accumulator wrong");

	property p_add_file;
		(phase == ph_q4 && cur_op == op_add_carry && ir[9]) |=>
			file_req.wr && file_req.wdata == $past(chk_sum[7:0]) && $stable(accum);
	endproperty
	a_add_file: assert property (p_add_file) else $error("add to file wrong");

	property p_bank_addr;
		(phase == ph_q2 && uses_file && ir[8]) |=> file_req.addr == {$past(bank_selector), $past(ir[7:0])};
	endproperty
	a_bank_addr: assert property (p_bank_addr) else $error("banked address wrong");

	property p_index_addr;
		(phase == ph_q2 && uses_file && !ir[8] && ext_en && ir[7:0] <= 8'h5f) |=>
			file_req.addr == $past(index_base) + 12'($past(ir[7:0]));
	endproperty
	a_index_addr: assert property (p_index_addr) else $error("indexed address wrong");

	property p_and_lit;
		(phase == ph_q4 && cur_op == op_and_lit) |=>
			accum == ($past(accum) & $past(ir[7:0])) && $stable(status.c) && $stable(status.ov) &&
			$stable(status.digit_carry_flag);
	endproperty
	a_and_lit: assert property (p_and_lit) else $error("and literal wrong");

	property p_and_file;
		(phase == ph_q4 && cur_op == op_and_file && ir[9]) |=>
			file_req.wr && file_req.wdata == ($past(accum) & $past(file_rdata));
	endproperty
	a_and_file: assert property (p_and_file) else $error("and file wrong");

	property p_branch_flags;
		(phase == ph_q4 && (cur_op == op_br_carry || cur_op == op_br_neg || cur_op == op_bit_clear)) |=>
			$stable(status);
	endproperty
	a_branch_flags: assert property (p_branch_flags) else $error("flags changed");

	property p_branch_target;
		(phase == ph_q4 && taken) |=> instruction_pointer == $past(instruction_pointer) + $past(br_offset);
	endproperty
	a_branch_target: assert property (p_branch_target) else $error("branch target wrong");

	property p_branch_idle;
		(phase == ph_q4 && taken) |=> flush ##1 (cur_op == op_nop) [*4] ##0 !flush;
	endproperty
	a_branch_idle: assert property (p_branch_idle) else $error("no idle cycle");

	property p_bn_fall;
		(phase == ph_q4 && cur_op == op_br_neg && !status.n) |=> $stable(instruction_pointer) && !flush;
	endproperty
	a_bn_fall: assert property (p_bn_fall) else $error("branch not expected");

	property p_bit_clear;
		(phase == ph_q4 && cur_op == op_bit_clear) |=>
			file_req.wr && file_req.wdata == ($past(file_rdata) & ~(8'h01 << $past(ir[11:9])));
	endproperty
	a_bit_clear: assert property (p_bit_clear) else $error("bit clear wrong");

	property p_phases;
		file_req.rd |-> phase == ph_q3 ##1 phase == ph_q4 ##1 (phase == ph_q1 && !file_req.rd);
	endproperty
	a_phases: assert property (p_phases) else $error("phase order wrong");

	c_taken:   cover property (phase == ph_q4 && taken);
	c_add_f:   cover property (phase == ph_q4 && cur_op == op_add_carry && ir[9]);
	c_indexed: cover property (phase == ph_q2 && uses_file && !ir[8] && ext_en);
	c_clear:   cover property (phase == ph_q4 && cur_op == op_bit_clear);

endmodule : instr_exec

`default_nettype wire

// File: logic/operand_addr.sv
/*
 Forms the data memory address of a file register operand.
 Assumes the bank selector and index base are held stable by the caller.
*/
`timescale 1ns/10ps
`default_nettype none
`include "core_consts.svh"

module operand_addr (
	input  wire logic [7:0]              f,
	input  wire logic                    a,
	input  wire logic                    ext_en,
	input  wire logic [3:0]              bank_sel,
	input  wire logic [`FILE_ADDR_W-1:0] index_base,
	output logic [`FILE_ADDR_W-1:0]      addr
);
	// Banked, indexed or access bank address
	always_comb begin
		if (a)
			addr = {bank_sel, f};
		else if (ext_en && (f <= `INDEX_LIMIT))
			addr = index_base + `FILE_ADDR_W'(f);
		else if (f < `ACCESS_SPLIT)
			addr = {4'h0, f};
		else
			addr = {`ACCESS_HI_BANK, f};
	end

endmodule : operand_addr

`default_nettype wire

// File: pkg/core_consts.svh
/*
 Constants for the instruction execute block: register offsets, field
 positions, reset values, opcode patterns and addressing limits.
 Assumes it is included by bare name from the package and the modules.
*/
`ifndef CORE_CONSTS_SVH
`define CORE_CONSTS_SVH

// Register port offsets
`define BUS_ADDR_W     3
`define REG_ACCUM      3'h0
`define REG_STATUS     3'h1
`define REG_BANK_SEL   3'h2
`define REG_CTRL       3'h3
`define REG_INDEX_LO   3'h4
`define REG_INDEX_HI   3'h5

// Field positions
`define CTRL_EXT_BIT   0
`define FLD_DEST_BIT   9
`define FLD_BANK_BIT   8

// Reset values
`define RST_ACCUM      8'h00
`define RST_STATUS     5'h00
`define RST_BANK_SEL   4'h0
`define RST_CTRL       1'b0
`define RST_INDEX      12'h000

// Opcode patterns, compared against the upper instruction bits
`define OPC_ADD_CARRY  6'h08
`define OPC_AND_FILE   6'h05
`define OPC_AND_LIT    8'h0b
`define OPC_BR_CARRY   8'he2
`define OPC_BR_NEG     8'he6
`define OPC_BIT_CLR    4'h9

// Data memory addressing
`define FILE_ADDR_W    12
`define ACCESS_SPLIT   8'h60
`define INDEX_LIMIT    8'h5f
`define ACCESS_HI_BANK 4'hf
`define PC_STEP        2

`endif

// File: pkg/core_pkg.sv
/*
 Types shared by the instruction execute block: operations, phases,
 status flags and the data memory request.
 Assumes core_consts.svh is on the include path.
*/
`include "core_consts.svh"

package core_pkg;

	// Decoded operations of the supported subset
	typedef enum logic [2:0] {
		op_nop       = 3'b000,
		op_add_carry = 3'b001,
		op_and_lit   = 3'b010,
		op_and_file  = 3'b011,
		op_br_carry  = 3'b100,
		op_bit_clear = 3'b101,
		op_br_neg    = 3'b110
	} op_e;

	// Four phases of one instruction cycle
	typedef enum logic [1:0] {
		ph_q1 = 2'b00,
		ph_q2 = 2'b01,
		ph_q3 = 2'b10,
		ph_q4 = 2'b11
	} phase_e;

	// Flag order puts carry in bit 0 and negative in bit 4
	typedef struct packed {
		logic n;
		logic ov;
		logic z;
		logic digit_carry_flag;
		logic c;
	} status_s;

	// Data memory request toward the file registers
	typedef struct packed {
		logic [`FILE_ADDR_W-1:0] addr;
		logic                    rd;
		logic                    wr;
		logic [7:0]              wdata;
	} file_req_s;

endpackage : core_pkg

// File: verification/tb.sv
/*
 Self-checking bench for the instruction execute block: arithmetic and logic
 operations, operand addressing, bit clear and both conditional branches.
 Assumes core_pkg and core_consts.svh are compiled first; no file memory
 model, the bench drives file_rdata itself.
*/
`timescale 1ns/10ps
`default_nettype none
`include "core_consts.svh"

module tb;
	import core_pkg::*;

	logic             clk_sys;
	logic             reset;
	logic [15:0]      instr_word;
	logic             instr_valid;
	logic [7:0]       file_rdata;
	logic [2:0]       bus_addr;
	logic [7:0]       bus_wdata;
	logic             bus_wr;
	logic             bus_rd;
	file_req_s        file_req;
	status_s          status;
	phase_e           phase;
	logic [7:0]       accum;
	logic [20:0]      instruction_pointer;
	logic             flush;
	logic [7:0]       bus_rdata;
	int               err_total;
	int               cmp_count;
	logic [20:0]      pc0;
	file_req_s        req3;
	file_req_s        req4;
	logic [7:0]       rd_val;

	instr_exec #(.PC_W(21)) i_instr_exec (
		.instr_word(instr_word), .clk_sys(clk_sys), .reset(reset), .instr_valid(instr_valid),
		.file_rdata(file_rdata), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
		.bus_rd(bus_rd), .file_req(file_req), .status(status), .phase(phase), .accum(accum),
		.instruction_pointer(instruction_pointer), .flush(flush), .bus_rdata(bus_rdata)
	);

	////////////////////////////////////////////////////////////////////////////
	// 100 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	////////////////////////////////////////////////////////////////////////////
	// Compare, verdict and bus tasks
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic end_of_test;
		$display("Comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : end_of_test

	// Each call leaves one idle edge, so strobes never get assigned twice at once
	task automatic bwr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge clk_sys);
		bus_wr <= 1'b0;
	endtask : bwr

	task automatic brd(input logic [2:0] a);
		@(posedge clk_sys);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge clk_sys);
		bus_rd <= 1'b0;
		@(negedge clk_sys);
		rd_val = bus_rdata;
	endtask : brd

	// Runs one word through Q1..Q4; fw/fv is presented in the following Q1
	task automatic exec(input logic [15:0] w, input logic [7:0] fd, input logic [15:0] fw, input logic fv);
		int n;
		n = 0;
		do begin
			@(negedge clk_sys);
			n++;
		end while (phase !== ph_q4 && n < 8);
		chk("phase", ph_q4, phase);
		@(posedge clk_sys);
		instr_word <= w;
		instr_valid <= 1'b1;
		file_rdata <= fd;
		@(negedge clk_sys);
		pc0 = instruction_pointer;
		@(posedge clk_sys);
		instr_valid <= 1'b0;
		@(negedge clk_sys);
		@(negedge clk_sys);
		req3 = file_req;
		@(negedge clk_sys);
		@(posedge clk_sys);
		instr_word <= fw;
		instr_valid <= fv;
		@(negedge clk_sys);
		req4 = file_req;
		@(posedge clk_sys);
		instr_valid <= 1'b0;
		// Results are read off the edge, once this edge's updates have settled
		@(negedge clk_sys);
	endtask : exec

	function automatic logic [20:0] tgt(input logic [20:0] p, input logic [7:0] off);
		return p + 21'h000002 + {{12{off[7]}}, off, 1'b0};
	endfunction : tgt

	////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_and_lit;
		bwr(`REG_ACCUM, 8'hff);
		exec(16'h0b80, 8'h00, 16'h0000, 1'b0);
		chk("accum", 32'h80, accum);
		chk("status", 32'h10, status);
		chk("pc", tgt(pc0, 8'h00), instruction_pointer);
		exec(16'h0b00, 8'h00, 16'h0000, 1'b0);
		chk("status", 32'h04, status);
		brd(`REG_ACCUM);
		chk("accum read", 32'h00, rd_val);
		brd(3'h7);
		chk("unmapped read", 32'h00, rd_val);
		$display("test and_lit done");
	endtask : t_and_lit

	task automatic t_add;
		bwr(`REG_ACCUM, 8'h7f);
		bwr(`REG_STATUS, 8'h01);
		exec(16'h2010, 8'h00, 16'h0000, 1'b0);
		chk("accum", 32'h80, accum);
		chk("status", 32'h1a, status);
		chk("addr", 32'h010, req3.addr);
		chk("rd", 32'h1, req3.rd);
		chk("wr", 32'h0, req4.wr);
		bwr(`REG_ACCUM, 8'hff);
		bwr(`REG_STATUS, 8'h01);
		bwr(`REG_BANK_SEL, 8'h03);
		exec(16'h2380, 8'h01, 16'h0000, 1'b0);
		chk("accum", 32'hff, accum);
		chk("status", 32'h03, status);
		chk("addr", 32'h380, req3.addr);
		chk("wr", 32'h1, req4.wr);
		chk("wdata", 32'h01, req4.wdata);
		$display("test add done");
	endtask : t_add

	task automatic t_and_file;
		bwr(`REG_CTRL, 8'h01);
		bwr(`REG_INDEX_LO, 8'h20);
		bwr(`REG_INDEX_HI, 8'h01);
		bwr(`REG_ACCUM, 8'h0f);
		exec(16'h1460, 8'h3c, 16'h0000, 1'b0);
		chk("addr", 32'hf60, req3.addr);
		chk("accum", 32'h0c, accum);
		chk("status", 32'h03, status);
		exec(16'h165f, 8'hf0, 16'h0000, 1'b0);
		chk("addr", 32'h17f, req3.addr);
		chk("accum", 32'h0c, accum);
		chk("wdata", 32'h00, req4.wdata);
		chk("wr", 32'h1, req4.wr);
		chk("status", 32'h07, status);
		$display("test and_file done");
	endtask : t_and_file

	task automatic t_bit_clr;
		logic [7:0] m;
		bwr(`REG_CTRL, 8'h00);
		for (int b = 0; b < 8; b++) begin
			m = 8'h01 << b;
			exec(16'h9010 | (16'(b) << 9), 8'hff, 16'h0000, 1'b0);
			chk("wdata", {24'h000000, ~m}, req4.wdata);
			chk("wr", 32'h1, req4.wr);
			chk("addr", 32'h010, req4.addr);
		end
		chk("status", 32'h07, status);
		$display("test bit_clr done");
	endtask : t_bit_clr

	task automatic t_branch;
		// Carry set, negative clear; the word offered in the flushed cycle must die
		exec(16'he205, 8'h00, 16'h0b00, 1'b1);
		chk("pc", tgt(pc0, 8'h05), instruction_pointer);
		chk("flush", 32'h1, flush);
		chk("accum", 32'h0c, accum);
		chk("status", 32'h07, status);
		exec(16'he6fe, 8'h00, 16'h0000, 1'b0);
		chk("pc", tgt(pc0, 8'h00), instruction_pointer);
		chk("flush", 32'h0, flush);
		chk("accum", 32'h0c, accum);
		bwr(`REG_STATUS, 8'h10);
		exec(16'he27f, 8'h00, 16'h0000, 1'b0);
		chk("pc", tgt(pc0, 8'h00), instruction_pointer);
		chk("wr", 32'h0, req4.wr);
		exec(16'he680, 8'h00, 16'h0000, 1'b0);
		chk("pc", tgt(pc0, 8'h80), instruction_pointer);
		chk("status", 32'h10, status);
		$display("test branch done");
	endtask : t_branch

	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		err_total = 0;
		cmp_count = 0;
		reset = 1'b1;
		instr_word = 16'h0000;
		instr_valid = 1'b0;
		file_rdata = 8'h00;
		bus_addr = 3'h0;
		bus_wdata = 8'h00;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
		repeat (12) @(posedge clk_sys);
		reset <= 1'b0;
		t_and_lit();
		t_add();
		t_and_file();
		t_bit_clr();
		t_branch();
		end_of_test();
	end

	// Watchdog: the whole run needs well under 1000 cycles
	initial begin
		repeat (5000) @(posedge clk_sys);
		err_total++;
		end_of_test();
	end

endmodule : tb

`default_nettype wire
